// ---- charger_option_consts.svh ----
// Purpose: offsets, field positions, reset values for the option word
// Assumes: word transfers of 16 bits at one command code
// Notes:   definitions only
`ifndef CHARGER_OPTION_CONSTS_SVH
`define CHARGER_OPTION_CONSTS_SVH

`define OPT_CMD_CODE        8'h12
`define OPT_DEPL_HI         12
`define OPT_DEPL_LO         11
`define OPT_FREQ_DIR        10
`define OPT_FREQ_EN         9
`define OPT_HS_FAULT_EN     8
`define OPT_LS_FAULT_SEL    7
`define OPT_LEARN           6
`define OPT_MON_SEL         5
`define OPT_ADAPTER_PRESENT 4
`define OPT_BOOST_EN        3
`define OPT_BOOST_ACTIVE    2
`define OPT_ADAPTER_OC_EN   1
`define OPT_CHG_INHIBIT     0
// writable low bits power up as 1_1001_0000_0010
`define OPT_RESET_LOW       13'h1902
`define OPT_WRITE_MASK      13'h1feb
`define CV_ZERO             16'h0000

`endif

// ---- charger_option_pkg.sv ----
// Purpose: types shared by the option word logic
// Assumes: nothing
// Notes:   depletion threshold codes and source path states (adapter, learn, boost)
package charger_option_pkg;

    typedef enum logic [1:0] {
        depl_59p19    = 2'b00,
        depl_reserved = 2'b01,
        depl_62p65    = 2'b10,
        depl_70p97    = 2'b11
    } depl_code_t;

    typedef enum logic [1:0] {
        path_adapter = 2'b00,
        path_learn   = 2'b01,
        path_boost   = 2'b10
    } path_state_t;

endpackage

// ---- charger_option_control_low_bits.sv ----
// Purpose: low thirteen bits of the charger option word
// Assumes: a word port decoded from the serial interface; analog
//          comparators deliver synchronous logic levels
// Notes:   bits 15:13 live elsewhere and read as zero here
`timescale 1ns/1ns
`include "charger_option_consts.svh"

module charger_option_control_low_bits (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  cmd_code,
    input  wire logic        word_write,
    input  wire logic [15:0] word_wdata,
    output logic      [15:0] word_rdata,
    input  wire logic [15:0] charge_voltage_setting,
    input  wire logic        adapter_detect_above,
    input  wire logic        battery_below_falling,
    input  wire logic        battery_above_release,
    input  wire logic        boost_demand,
    output logic [1:0]       depletion_threshold_sel,
    output logic             depletion_tripped,
    output logic             freq_shift_active,
    output logic             freq_shift_up,
    output logic             high_side_fault_comparator_en,
    output logic             low_side_fault_comparator_hi,
    output logic             boost_current_limit_hi,
    output logic             current_monitor_output_sel,
    output logic             adapter_overcurrent_comparator_en,
    output logic             charge_enable,
    output logic             battery_path_switch,
    output logic             adapter_path_switch,
    output logic             boost_active
);

    // stored writable bits, learn included
    logic [12:0] opt_r;
    logic [12:0] opt_nxt;
    // depletion comparator with hysteresis
    logic        depl_r;
    logic        depl_nxt;
    charger_option_pkg::path_state_t path_r;
    charger_option_pkg::path_state_t path_nxt;

    // decode of the host port
    wire         hit        = (cmd_code == `OPT_CMD_CODE);
    wire         wr_hit     = word_write && hit;
    wire         depl_on    = (charge_voltage_setting != `CV_ZERO);
    wire         learn_bit  = opt_r[`OPT_LEARN];
    wire         boost_ok   = opt_r[`OPT_BOOST_EN] && depl_on;
    // code 01 is not a valid setting; comparator takes no action on it
    wire         code_ok    = (opt_r[`OPT_DEPL_HI:`OPT_DEPL_LO]
                               != charger_option_pkg::depl_reserved);
    wire         depl_valid = depl_on && code_ok;
    wire         learn_done = (path_r == charger_option_pkg::path_learn)
                              && depl_r;

    // trip below falling edge, release above +340mV point or at once when depl_valid is low
    assign depl_nxt = !depl_valid ? 1'b0 :
                      battery_below_falling ? 1'b1 :
                      battery_above_release ? 1'b0 : depl_r;

    // host writes masked; hardware clear of learn wins over write of 1
    always_comb
    begin
        opt_nxt = opt_r;
        if (wr_hit)
            opt_nxt = (opt_r & ~`OPT_WRITE_MASK)
                      | (word_wdata[12:0] & `OPT_WRITE_MASK);
        if (learn_done)
            opt_nxt[`OPT_LEARN] = 1'b0;
    end

    // source selection between adapter, learn and boost
    always_comb
    begin
        path_nxt = path_r;
        unique case (path_r)
            charger_option_pkg::path_adapter:
            begin
                if (learn_bit && !depl_r)
                    path_nxt = charger_option_pkg::path_learn;
                else if (boost_ok && boost_demand && !depl_r)
                    path_nxt = charger_option_pkg::path_boost;
            end
            charger_option_pkg::path_learn:
            begin
                if (!learn_bit || depl_r)
                    path_nxt = charger_option_pkg::path_adapter;
            end
            charger_option_pkg::path_boost:
            begin
                if (depl_r || !boost_ok || !boost_demand)
                    path_nxt = charger_option_pkg::path_adapter;
                else if (learn_bit)
                    path_nxt = charger_option_pkg::path_learn;
            end
            default:
                path_nxt = charger_option_pkg::path_adapter;
        endcase
    end

    // state registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            opt_r  <= `OPT_RESET_LOW;
            depl_r <= 1'b0;
            path_r <= charger_option_pkg::path_adapter;
        end
        else
        begin
            opt_r  <= opt_nxt;
            depl_r <= depl_nxt;
            path_r <= path_nxt;
        end
    end

    // reset image of the stored bits, shared by the field output flops and charge_enable
    localparam logic [12:0] opt_rst = `OPT_RESET_LOW;

    // which source the next edge leaves in force
    wire        in_adapter = (path_nxt == charger_option_pkg::path_adapter);
    wire        in_learn   = (path_nxt == charger_option_pkg::path_learn);
    wire        in_boost   = (path_nxt == charger_option_pkg::path_boost);

    // read word: stored bits plus live status, top bits read zero
    wire [15:0] rdata_nxt  = {3'h0, opt_nxt[12:5],
                              adapter_detect_above,
                              opt_nxt[`OPT_BOOST_EN],
                              in_boost,
                              opt_nxt[`OPT_ADAPTER_OC_EN:`OPT_CHG_INHIBIT]};

    // boost limit and charging follow the source in force
    wire        limit_nxt  = opt_nxt[`OPT_LS_FAULT_SEL] && in_boost;
    wire        charge_nxt = !opt_nxt[`OPT_CHG_INHIBIT]
                             && in_adapter;

    // read word register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            word_rdata <= 16'h0000;
        end
        else
        begin
            word_rdata <= rdata_nxt;
        end
    end

    // depletion threshold code to the comparator
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            depletion_threshold_sel <= opt_rst[`OPT_DEPL_HI:`OPT_DEPL_LO];
        end
        else
        begin
            depletion_threshold_sel <=
                opt_nxt[`OPT_DEPL_HI:`OPT_DEPL_LO];
        end
    end

    // comparator state as seen outside
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            depletion_tripped <= 1'h0;
        end
        else
        begin
            depletion_tripped <= depl_nxt;
        end
    end

    // frequency shift enable
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            freq_shift_active <= opt_rst[`OPT_FREQ_EN];
        end
        else
        begin
            freq_shift_active <= opt_nxt[`OPT_FREQ_EN];
        end
    end

    // frequency shift direction
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            freq_shift_up <= opt_rst[`OPT_FREQ_DIR];
        end
        else
        begin
            freq_shift_up <= opt_nxt[`OPT_FREQ_DIR];
        end
    end

    // high-side short-circuit comparator enable
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            high_side_fault_comparator_en <= opt_rst[`OPT_HS_FAULT_EN];
        end
        else
        begin
            high_side_fault_comparator_en <=
                opt_nxt[`OPT_HS_FAULT_EN];
        end
    end

    // low-side short-circuit threshold select
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            low_side_fault_comparator_hi <= opt_rst[`OPT_LS_FAULT_SEL];
        end
        else
        begin
            low_side_fault_comparator_hi <=
                opt_nxt[`OPT_LS_FAULT_SEL];
        end
    end

    // boost cycle-by-cycle limit select
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            boost_current_limit_hi <= 1'h0;
        end
        else
        begin
            boost_current_limit_hi <= limit_nxt;
        end
    end

    // current monitor source select
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            current_monitor_output_sel <= opt_rst[`OPT_MON_SEL];
        end
        else
        begin
            current_monitor_output_sel <= opt_nxt[`OPT_MON_SEL];
        end
    end

    // input overcurrent comparator enable
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            adapter_overcurrent_comparator_en <= opt_rst[`OPT_ADAPTER_OC_EN];
        end
        else
        begin
            adapter_overcurrent_comparator_en <=
                opt_nxt[`OPT_ADAPTER_OC_EN];
        end
    end

    // charging allowed only from the adapter with inhibit clear
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            charge_enable <= !opt_rst[`OPT_CHG_INHIBIT];
        end
        else
        begin
            charge_enable <= charge_nxt;
        end
    end

    // battery path closed in learn or boost
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            battery_path_switch <= 1'h0;
        end
        else
        begin
            battery_path_switch <= !in_adapter;
        end
    end

    // adapter path opened only in learn
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            adapter_path_switch <= 1'h1;
        end
        else
        begin
            adapter_path_switch <= !in_learn;
        end
    end

    // boost mode indication
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            boost_active <= 1'h0;
        end
        else
        begin
            boost_active <= in_boost;
        end
    end

endmodule // charger_option_control_low_bits

// ---- charger_option_sva.sv ----
// Purpose: port checker for the option word low bits
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound onto the design top
`timescale 1ns/1ns
module charger_option_sva (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        word_write,
    input wire logic        depletion_tripped,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] word_wdata,
    input wire logic [15:0] word_rdata,
    input wire logic [1:0]  depletion_threshold_sel,
    input wire logic        freq_shift_up,
    input wire logic        freq_shift_active,
    input wire logic        charge_enable,
    input wire logic        high_side_fault_comparator_en,
    input wire logic        boost_active,
    input wire logic        low_side_fault_comparator_hi,
    input wire logic        adapter_detect_above,
    input wire logic        current_monitor_output_sel,
    input wire logic        battery_path_switch,
    input wire logic        adapter_overcurrent_comparator_en,
    input wire logic        adapter_path_switch
);
    // write to this word taken at an edge
    wire word_taken = word_write && cmd_code == 8'h12;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // register view and side effects
    property p_top; word_rdata[15:13] == 3'h0; endproperty
    a_top: assert property (p_top) else $error("top bits set");
    property p_ad; !$past(rst) |-> word_rdata[4] == $past(adapter_detect_above);
    endproperty
    a_ad: assert property (p_ad) else $error("presence bit");
    property p_wr; word_taken |=>
        (word_rdata & 16'h1fab) == ($past(word_wdata) & 16'h1fab); endproperty
    a_wr: assert property (p_wr) else $error("write lost");
    property p_mir; !$past(rst) |-> {depletion_threshold_sel, freq_shift_up,
        freq_shift_active, high_side_fault_comparator_en} ==
        word_rdata[12:8]; endproperty
    a_mir: assert property (p_mir) else $error("field output");
    property p_mlo; !$past(rst) |-> {low_side_fault_comparator_hi,
        current_monitor_output_sel, adapter_overcurrent_comparator_en} ==
        {word_rdata[7], word_rdata[5], word_rdata[1]}; endproperty
    a_mlo: assert property (p_mlo) else $error("low fields");
    property p_ls; word_taken && word_wdata[6] && !depletion_tripped &&
        !boost_active |-> ##[1:2] (battery_path_switch && !adapter_path_switch);
    endproperty
    a_ls: assert property (p_ls) else $error("learn start");
    property p_lx; word_taken && !word_wdata[6] && word_rdata[6] &&
        !boost_active |-> ##[1:2] (adapter_path_switch && !battery_path_switch);
    endproperty
    a_lx: assert property (p_lx) else $error("learn stop");
    property p_tr; !adapter_path_switch && depletion_tripped |-> ##[1:2]
        (adapter_path_switch && !battery_path_switch && !word_rdata[6]);
    endproperty
    a_tr: assert property (p_tr) else $error("learn end");
    property p_be; boost_active && depletion_tripped |-> ##[1:2] !boost_active;
    endproperty
    a_be: assert property (p_be) else $error("boost end");
    property p_ci; word_rdata[0] |-> !charge_enable; endproperty
    a_ci: assert property (p_ci) else $error("inhibit");
endmodule // charger_option_sva

bind charger_option_control_low_bits charger_option_sva u_sva (.*);

// ---- smbus_host_model.sv ----
// Purpose: host side issuing option word transfers
// Assumes: drives off the falling edge
// Notes:   one whole word per write pulse
`timescale 1ns/1ns
module smbus_host_model (
    input  wire logic        clock,
    output logic      [7:0]  cmd_code,
    output logic             word_write,
    output logic      [15:0] word_wdata
);
    initial {cmd_code, word_write, word_wdata} = '0;
    // one 16-bit word write, data scrambled after release
    task automatic put(input logic [7:0] c, input logic [15:0] w);
        @(negedge clock);
        cmd_code = c;
        word_write = 1'b1;
        word_wdata = w;
        @(negedge clock);
        word_write = 1'b0;
        word_wdata = ~w;
    endtask
endmodule // smbus_host_model

// ---- tb.sv ----
// Purpose: self-checking bench for the option word low bits
// Assumes: host model drives the word port
// Notes:   levels driven at the falling edge
`timescale 1ns/1ns
module tb;
    logic        clock = 1'b0, rst = 1'b1, ad = 1'b1, bbf = 1'b0;
    logic        bar = 1'b1, bd = 1'b0, wr, trip, fa, fu, hs, ls, bcl;
    logic        mon, oc, ce, bp, ap, ba;
    logic [7:0]  cmd;
    logic [15:0] cv = 16'h3000, wd, rd;
    logic [1:0]  sel;
    int          fail_count = 0, comparisons = 0;
    // clock and parts
    always #25 clock = ~clock;
    smbus_host_model host (.clock(clock), .cmd_code(cmd), .word_write(wr),
        .word_wdata(wd));
    charger_option_control_low_bits dut (.clock(clock), .rst(rst),
        .cmd_code(cmd), .word_write(wr), .word_wdata(wd), .word_rdata(rd),
        .charge_voltage_setting(cv), .adapter_detect_above(ad),
        .battery_below_falling(bbf), .battery_above_release(bar),
        .boost_demand(bd), .depletion_threshold_sel(sel),
        .depletion_tripped(trip), .freq_shift_active(fa), .freq_shift_up(fu),
        .high_side_fault_comparator_en(hs), .low_side_fault_comparator_hi(ls),
        .boost_current_limit_hi(bcl), .current_monitor_output_sel(mon),
        .adapter_overcurrent_comparator_en(oc), .charge_enable(ce),
        .battery_path_switch(bp), .adapter_path_switch(ap), .boost_active(ba));
    // compare, wait, finish
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // power-on values, fields, codes, read-only bits
    task automatic t_fields;
        chk(rd, 16'h1912);
        chk(16'({sel, hs, oc, ce, ap, bp, ba}), 16'h00fc);
        host.put(8'h13, 16'hffbf);
        chk(rd, 16'h1912);
        host.put(8'h12, 16'hffbf);
        chk(rd, 16'h1fbb);
        chk(16'({fu, fa, hs, ls, mon, oc, ce}), 16'h007e);
        for (int i = 0; i < 4; i++)
        begin
            host.put(8'h12, 16'(i) << 11);
            chk(16'(sel), 16'(i));
        end
        chk(16'({fu, fa, hs, ls, mon, oc, ce}), 16'h0001);
        ad = 1'b0;
        cyc(1);
        chk(rd, 16'h1800);
    endtask
    // learn start, depletion end, hysteresis, host stop
    task automatic t_learn;
        host.put(8'h12, 16'h1840);
        cyc(2);
        chk(16'({bp, ap, ce}), 16'h0004);
        bbf = 1'b1;
        bar = 1'b0;
        cyc(3);
        chk(16'({bp, ap, rd[6], trip}), 16'h0005);
        bbf = 1'b0;
        cyc(3);
        chk(16'(trip), 16'h0001);
        bar = 1'b1;
        cyc(2);
        chk(16'(trip), 16'h0000);
        host.put(8'h12, 16'h1840);
        cyc(2);
        host.put(8'h12, 16'h1800);
        cyc(1);
        chk(16'({bp, ap}), 16'h0001);
    endtask
    // boost gate, indication, limit, depletion stop
    task automatic t_boost;
        bd = 1'b1;
        cyc(2);
        chk(16'(ba), 16'h0000);
        host.put(8'h12, 16'h1808);
        cyc(2);
        chk(16'({ba, rd[2], bp, bcl}), 16'h000e);
        host.put(8'h12, 16'h1888);
        cyc(1);
        chk(16'(bcl), 16'h0001);
        bbf = 1'b1;
        bar = 1'b0;
        cyc(3);
        chk(16'(ba), 16'h0000);
        host.put(8'h12, 16'h1880);
        bbf = 1'b0;
        bar = 1'b1;
        cyc(2);
        chk(16'(ba), 16'h0000);
        bd = 1'b0;
        cv = 16'h0000;
        bbf = 1'b1;
        cyc(3);
        chk(16'(trip), 16'h0000);
    endtask
    // main sequence
    initial
    begin
        cyc(20);
        rst = 1'b0;
        cyc(1);
        t_fields;
        t_learn;
        t_boost;
        end_sim;
    end
    // watchdog
    initial
    begin
        #(2000 * 50);
        fail_count++;
        end_sim;
    end
endmodule // tb
